/* File: logic/acc_serial_port.sv */
module acc_serial_port
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,

  // Host pins
  input  wire logic                    conversion_start_pin_i,
  input  wire logic                    cs_n_i,
  input  wire logic                    sclk_i,
  input  wire logic                    sdi_i,
  output logic                         serial_out_lane0_o,
  output logic                         serial_out_lane0_oe_o,
  output logic                         ready_strobe_pin_o,

  // Converter core
  input  wire logic [ACC_SAMPLE_W-1:0] sample_data_i,
  output logic                         sample_taken_o,

  // Power state
  output logic                         power_down_o,
  output logic                         light_sleep_o
);

  // Pin synchronisation
  acc_link_s pins_raw;
  acc_link_s pins_s;
  acc_link_s pins_prev_q;

  assign pins_raw.conv_start = conversion_start_pin_i;
  assign pins_raw.cs_n       = cs_n_i;
  assign pins_raw.sclk       = sclk_i;
  assign pins_raw.sdi        = sdi_i;

  acc_sync #(
    .WIDTH     ($bits(acc_link_s)),
    .RESET_VAL (ACC_LINK_IDLE)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (pins_raw),
    .sync_o   (pins_s)
  );

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pins_prev_q <= ACC_LINK_IDLE;
    end else begin
      pins_prev_q <= pins_s;
    end
  end

  // Registers
  logic [7:0]       power_q;
  logic [7:0]       inprot_q;
  logic [7:0]       outprot_q;
  logic [7:0]       format_q;
  logic             key_armed_q;
  logic             readback_q;
  logic [7:0]       readback_data_q;

  // Link state
  acc_frame_e       frame_q;
  logic [ACC_WORD_W-1:0] shift_q;
  logic [ACC_SAMPLE_W-1:0] sample_q;
  logic             cpol_q;
  logic             cpha_q;

  // Edge detection on synchronised pins
  logic start_rise;
  logic cs_fall;
  logic cs_rise;
  logic lead_edge;
  logic trail_edge;
  logic launch;
  logic capture;
  logic sclk_act;
  logic sclk_act_prev;

  assign start_rise  = pins_s.conv_start &
                       ~pins_prev_q.conv_start; // see RULE_03
  assign cs_fall     = ~pins_s.cs_n & pins_prev_q.cs_n; // see RULE_04
  assign cs_rise     = pins_s.cs_n & ~pins_prev_q.cs_n; // see RULE_07

  // Polarity is latched at frame start so a mode write takes effect next frame
  assign sclk_act      = pins_s.sclk ^ cpol_q;
  assign sclk_act_prev = pins_prev_q.sclk ^ cpol_q;
  assign lead_edge     = sclk_act & ~sclk_act_prev;
  assign trail_edge    = ~sclk_act & sclk_act_prev;

  // Phase 0 captures on the leading edge, phase 1 on the trailing
  assign capture = (frame_q == ACC_FRAME) &&
                   (cpha_q ? trail_edge : lead_edge); // see RULE_17
  assign launch  = (frame_q == ACC_FRAME) &&
                   (cpha_q ? lead_edge : trail_edge); // see RULE_17

  // Output data word build
  function automatic logic parity_span(input logic [15:0] d,
                                       input logic [1:0]  span);
    logic p;
    p = 1'b0;
    unique case (span)
      2'b00: p = ^d[15:12];
      2'b01: p = ^d[15:8];
      2'b10: p = ^d[15:4];
      2'b11: p = ^d;
    endcase
    return p;
  endfunction

  logic [15:0]           word_body;
  logic [ACC_WORD_W-1:0] out_word;

  always_comb begin
    word_body = sample_q;
    if (format_q[2]) begin
      unique case (format_q[1:0])
        2'b00: word_body = 16'h0000;
        2'b01: word_body = 16'hffff;
        2'b10: word_body = 16'h5555;
        2'b11: word_body = 16'h3333;
      endcase
    end
    out_word = {word_body, 4'h0};
    if (format_q[ACC_BIT_PAR_EN]) begin
      out_word[3] = ^word_body;
      out_word[2] = parity_span(word_body, format_q[5:4]);
    end
    if (readback_q) begin
      out_word = {12'h000, readback_data_q};
    end
  end

  // Conversion capture; a powered-down core takes no samples
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sample_q       <= '0;
      sample_taken_o <= 1'b0;
    end else begin
      sample_taken_o <= 1'b0;
      if (start_rise && !power_q[ACC_BIT_POWER_DOWN]) begin // see RULE_03
        sample_q       <= sample_data_i;
        sample_taken_o <= 1'b1;
      end
    end
  end

  // Frame tracking
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      frame_q <= ACC_IDLE;
      cpol_q  <= 1'b0;
      cpha_q  <= 1'b0;
    end else begin
      unique case (frame_q)
        ACC_IDLE: begin
          if (cs_fall) begin // see RULE_04
            frame_q <= ACC_FRAME;
            cpha_q  <= inprot_q[ACC_BIT_CPHA];
          end else begin
            cpol_q  <= inprot_q[ACC_BIT_CPOL];
          end
        end
        ACC_FRAME: begin
          if (cs_rise) begin
            frame_q <= ACC_IDLE;
          end
        end
      endcase
    end
  end

  // Unified shift register: one word serves output and input
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      shift_q <= '0;
    end else if (cs_fall && frame_q == ACC_IDLE) begin
      shift_q <= out_word; // see RULE_02
    end else if (capture) begin
      shift_q <= {shift_q[ACC_WORD_W-2:0], pins_s.sdi}; // see RULE_06
    end
  end

  // Serial output lane 0, released between frames for shared lines
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      serial_out_lane0_o    <= 1'b0;
      serial_out_lane0_oe_o <= 1'b0;
    end else begin
      if (cs_fall && frame_q == ACC_IDLE) begin
        serial_out_lane0_o    <= out_word[ACC_WORD_W-1];
        serial_out_lane0_oe_o <= 1'b1;
      end else if (launch) begin
        serial_out_lane0_o    <= shift_q[ACC_WORD_W-1]; // see RULE_05
      end
      if (pins_s.cs_n) begin
        serial_out_lane0_oe_o <= 1'b0; // see RULE_21
      end
    end
  end

  // Ready strobe stays low through a frame
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ready_strobe_pin_o <= 1'b1;
    end else begin
      ready_strobe_pin_o <= pins_s.cs_n;
    end
  end

  // Command decode at frame end
  acc_cmd_s cmd;
  logic     do_write;
  logic     do_read;

  assign cmd      = acc_cmd_s'(shift_q);
  assign do_write = cs_rise && frame_q == ACC_FRAME &&
                    cmd.op == ACC_OP_WRITE; // see RULE_07
  assign do_read  = cs_rise && frame_q == ACC_FRAME &&
                    cmd.op == ACC_OP_READ;

  // Key is consumed by whatever command follows it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      key_armed_q <= 1'b0;
    end else if (cs_rise && frame_q == ACC_FRAME) begin
      key_armed_q <= do_write && cmd.addr == ACC_ADDR_KEY &&
                     cmd.data == ACC_KEY_VALUE; // see RULE_14
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      power_q <= ACC_RESET_REG; // see RULE_15 see RULE_16
    end else if (do_write && cmd.addr == ACC_ADDR_POWER && key_armed_q) begin
      power_q <= cmd.data & ACC_MASK_POWER; // see RULE_14 see RULE_20
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      inprot_q <= ACC_RESET_REG;
    end else if (do_write && cmd.addr == ACC_ADDR_INPROT) begin
      inprot_q <= cmd.data & ACC_MASK_INPROT; // see RULE_18
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      outprot_q <= ACC_RESET_REG;
    end else if (do_write && cmd.addr == ACC_ADDR_OUTPROT) begin
      outprot_q <= cmd.data & ACC_MASK_OUTPROT; // see RULE_13
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      format_q <= ACC_RESET_REG;
    end else if (do_write && cmd.addr == ACC_ADDR_FORMAT) begin
      format_q <= cmd.data & ACC_MASK_FORMAT; // see RULE_13
    end
  end

  // Read-back replaces the sample in the next frame only
  logic [7:0] read_mux;

  always_comb begin
    read_mux = 8'h00;
    unique case (cmd.addr)
      ACC_ADDR_POWER:   read_mux = power_q; // see RULE_18
      ACC_ADDR_INPROT:  read_mux = inprot_q; // see RULE_18
      ACC_ADDR_OUTPROT: read_mux = outprot_q;
      ACC_ADDR_FORMAT:  read_mux = format_q;
      default:          read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      readback_q      <= 1'b0;
      readback_data_q <= 8'h00;
    end else if (do_read) begin
      readback_q      <= 1'b1;
      readback_data_q <= read_mux;
    end else if (cs_rise && frame_q == ACC_FRAME) begin
      readback_q      <= 1'b0;
    end
  end

  // Power state outputs
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      power_down_o  <= 1'b0;
      light_sleep_o <= 1'b0;
    end else begin
      power_down_o  <= power_q[ACC_BIT_POWER_DOWN]; // see RULE_16
      light_sleep_o <= power_q[ACC_BIT_LIGHT_SLEEP]; // see RULE_15
    end
  end

  // Conversion start and chip select pass through the same two-stage synchroniser,
  // so tying them together only moves the sample to the frame end
  // see RULE_19

endmodule // acc_serial_port

/* File: logic/acc_pkg.sv */
// Behaviour
// RULE_01: Chained host writes same config everywhere and keeps output protocol at zero.
// RULE_02: Chained mode merges output and input data into one 20-bit shift register.
// RULE_03: Analog input is sampled on the conversion start rising edge.
// RULE_04: A frame starts when chip select falls.
// RULE_05: Each launch edge drives the shift register MSB onto serial output lane 0.
// RULE_06: Each capture edge shifts the serial input into the shift register LSB.
// RULE_07: On chip select rising the shift register is decoded as a command.
// RULE_08: Host gets chained words last device first, MSB first.
// RULE_09: Host gives twenty capture edges per chained device in an optimal frame.
// RULE_10: Longer frames need host to align each device's bits before chip select rises.
// RULE_11: Host never sends fewer than twenty clocks per chained device.
// RULE_12: In star topology host selects only one device at a time.
// RULE_13: Four config registers at 010h, 014h, 018h, 01Ch.
// RULE_14: Power control writes need the key 69h written to address 011h first.
// RULE_15: Power control bit 1 enables light sleep; resets to zero.
// RULE_16: Power control bit 0 powers the device down; resets to zero.
// RULE_17: Write protocol field picks SPI polarity and phase, 00b to 11b.
// RULE_18: Bits seven to two of power and input protocol registers read zero.
// RULE_19: Device works with conversion start tied to chip select.
// RULE_20: Power control write without the key just before leaves it unchanged.
// RULE_21: Serial output lane 0 is released while chip select is high.
package acc_pkg;

  localparam int unsigned ACC_WORD_W = 20;
  localparam int unsigned ACC_SAMPLE_W = 16;

  // Register offsets
  localparam logic [7:0] ACC_ADDR_POWER = 8'h10;
  localparam logic [7:0] ACC_ADDR_KEY = 8'h11;
  localparam logic [7:0] ACC_ADDR_INPROT = 8'h14;
  localparam logic [7:0] ACC_ADDR_OUTPROT = 8'h18;
  localparam logic [7:0] ACC_ADDR_FORMAT = 8'h1c;
  localparam logic [7:0] ACC_KEY_VALUE = 8'h69;

  // Writable bit masks and reset values
  localparam logic [7:0] ACC_MASK_POWER = 8'h03;
  localparam logic [7:0] ACC_MASK_INPROT = 8'h03;
  localparam logic [7:0] ACC_MASK_OUTPROT = 8'hdf;
  localparam logic [7:0] ACC_MASK_FORMAT = 8'h3f;
  localparam logic [7:0] ACC_RESET_REG = 8'h00;

  // Field positions
  localparam int unsigned ACC_BIT_POWER_DOWN = 0;
  localparam int unsigned ACC_BIT_LIGHT_SLEEP = 1;
  localparam int unsigned ACC_BIT_CPHA = 0;
  localparam int unsigned ACC_BIT_CPOL = 1;
  localparam int unsigned ACC_BIT_PAR_EN = 3;

  // Command opcodes in word bits 19:16
  localparam logic [3:0] ACC_OP_NOP = 4'h0;
  localparam logic [3:0] ACC_OP_WRITE = 4'h1;
  localparam logic [3:0] ACC_OP_READ = 4'h2;

  // Synchroniser depth in cycles
  localparam int unsigned ACC_SYNC_STAGES = 2;

  typedef struct packed {
    logic [3:0] op;
    logic [7:0] addr;
    logic [7:0] data;
  } acc_cmd_s;

  typedef struct packed {
    logic conv_start;
    logic cs_n;
    logic sclk;
    logic sdi;
  } acc_link_s;

  // Pin levels while no frame runs; the synchroniser starts from these
  // so that no false select edge follows reset
  localparam acc_link_s ACC_LINK_IDLE = '{
    conv_start: 1'b0, cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0
  };

  typedef enum logic [0:0] {
    ACC_IDLE,
    ACC_FRAME
  } acc_frame_e;

endpackage : acc_pkg

/* File: logic/acc_sync.sv */
module acc_sync
  import acc_pkg::*;
#(
  parameter int unsigned     WIDTH     = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Only the second stage is ever read
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
        meta_q[i] <= RESET_VAL[i];
        sync_q[i] <= RESET_VAL[i];
      end else begin
        meta_q[i] <= async_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_o = sync_q;

endmodule // acc_sync

/* File: test/acc_serial_port_properties.sv */
module acc_serial_port_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host pins
  input wire logic conversion_start_pin_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic serial_out_lane0_o,
  input wire logic serial_out_lane0_oe_o,
  input wire logic ready_strobe_pin_o,
  // Core and power
  input wire logic sample_taken_o,
  input wire logic power_down_o,
  input wire logic light_sleep_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_frame_start: assert property (
    $fell(cs_n_i) |-> ##[1:5] serial_out_lane0_oe_o)
    else $error("lane not driven after select fell");
  a_lane_idle: assert property (
    cs_n_i [*5] |-> !serial_out_lane0_oe_o)
    else $error("lane driven while deselected");
  a_lane_drop: assert property (
    $rose(cs_n_i) |-> ##[1:5] !serial_out_lane0_oe_o)
    else $error("lane not released after frame");
  a_ready_low: assert property (
    !cs_n_i [*5] |-> !ready_strobe_pin_o)
    else $error("ready high inside frame");
  a_ready_idle: assert property (
    cs_n_i [*5] |-> ready_strobe_pin_o)
    else $error("ready low outside frame");
  a_sample_edge: assert property (
    $rose(conversion_start_pin_i) && !power_down_o
      |-> ##[1:5] sample_taken_o)
    else $error("no sample after start edge");
  a_sample_up: assert property (
    sample_taken_o |-> !power_down_o)
    else $error("sample taken while powered down");
  a_power_cs: assert property (
    !$stable({power_down_o, light_sleep_o}) |-> cs_n_i)
    else $error("power state changed inside frame");
  a_lane_hold: assert property (
    ($stable(sclk_i) && $stable(cs_n_i)) [*6]
      |-> $stable(serial_out_lane0_o))
    else $error("lane changed without clock edge");
endmodule // acc_serial_port_properties

/* File: test/acc_host_model.sv */
module acc_host_model
  import acc_pkg::*;
(
  // Host pins
  output acc_link_s   link_o,
  input  wire logic   sdo_i,
  // Captured word, done toggles per frame
  output logic [39:0] word_o,
  output logic        done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam time HALF = 80ns;

  initial begin
    link_o = ACC_LINK_IDLE;
    word_o = '0;
    done_o = 1'b0;
  end

  task automatic convert(input logic v);
    link_o.conv_start = v;
  endtask

  // One device, so only one select; n is 20 per device or more
  task automatic frame(input logic [39:0] w, input int n,
                       input logic [1:0] m);
    word_o = '0;
    link_o.sclk = m[1];
    #HALF link_o.cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      if (!m[0]) link_o.sdi = w[i];
      #HALF link_o.sclk = ~m[1];
      if (m[0]) link_o.sdi = w[i];
      else word_o = {word_o[38:0], sdo_i};
      #HALF link_o.sclk = m[1];
      if (m[0]) word_o = {word_o[38:0], sdo_i};
    end
    // Command sits in the last 20 bits; the data line toggles only once
    // select is high, as in phase 1 the last capture edge came only one HALF before
    #HALF link_o.cs_n = 1'b1;
    link_o.sdi = ~link_o.sdi;
    #HALF done_o = ~done_o;
  endtask
endmodule // acc_host_model

/* File: test/acc_serial_port_tb.sv */
module acc_serial_port_tb
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [15:0] sample_q = 16'h0;
  acc_link_s   link;
  logic        sdo, oe, rdy, taken, pdn, lsl, done;
  logic        last_q = 1'b0;
  logic [39:0] word;
  logic [1:0]  mode_q = 2'h0;
  logic [39:0] exp_q[$];
  logic [39:0] msk_q[$];
  int          num_errors = 0;
  int          checked = 0;
  wire logic   line = oe ? sdo : ~last_q;

  always #2 clk_i = ~clk_i;
  // Released lane shows the inverse of its last driven bit
  always @(posedge clk_i) if (oe === 1'b1) last_q <= sdo;

  acc_serial_port uut (
    .clk_i, .resetn_i,
    .conversion_start_pin_i(link.conv_start), .cs_n_i(link.cs_n),
    .sclk_i(link.sclk), .sdi_i(link.sdi),
    .serial_out_lane0_o(sdo), .serial_out_lane0_oe_o(oe),
    .ready_strobe_pin_o(rdy), .sample_data_i(sample_q),
    .sample_taken_o(taken), .power_down_o(pdn), .light_sleep_o(lsl)
  );
  acc_host_model u_host (.link_o(link), .sdo_i(line), .word_o(word),
                         .done_o(done));

  task automatic check(input logic [39:0] seen, input logic [39:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Output word per the format rules, with the held sample still zero
  function automatic logic [39:0] fmt_word(input logic [7:0] f);
    logic [15:0] b;
    logic [3:0]  t;
    b = 16'h0000;
    if (f[2]) b = f[1] ? (f[0] ? 16'h3333 : 16'h5555) : {16{f[0]}};
    t = 4'h0;
    if (f[3]) t = {^b, ^(b >> (4'd12 - 4'(4 * f[5:4]))), 2'b00};
    return {20'h0, b, t};
  endfunction

  always @(done) if (exp_q.size() != 0)
    check(word & msk_q.pop_front(), exp_q.pop_front(), "word");

  task automatic xfer(input logic [39:0] w, input int n,
                      input logic [39:0] e, input logic [39:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk_i);
    #1 u_host.frame(w, n, mode_q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer({20'h0, ACC_OP_WRITE, a, d}, 20, 40'h0, 40'h0);
  endtask

  // A read answers in the following frame
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    xfer({20'h0, ACC_OP_READ, a, 8'h00}, 20, 40'h0, 40'h0);
    xfer(40'h0, 20, {32'h0, d}, 40'hfffff);
  endtask

  initial begin : main
    logic [7:0]  d;
    logic [19:0] r;
    void'($urandom(15794));
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check(40'({rdy, oe}), 40'h2, "idle pins");
    for (int a = 0; a < 4; a++)
      rd(8'h10 + 8'(4 * a), 8'h00);
    wr(ACC_ADDR_POWER, 8'h03);
    rd(ACC_ADDR_POWER, 8'h00);
    wr(ACC_ADDR_KEY, ACC_KEY_VALUE);
    wr(ACC_ADDR_POWER, 8'hfe);
    rd(ACC_ADDR_POWER, 8'h02);
    check(40'({pdn, lsl}), 40'h1, "power pins");
    wr(ACC_ADDR_KEY, ACC_KEY_VALUE);
    wr(ACC_ADDR_POWER, 8'h01);
    check(40'({pdn, lsl}), 40'h2, "power pins");
    // Key is used up by the previous write
    wr(ACC_ADDR_POWER, 8'h00);
    check(40'({pdn, lsl}), 40'h2, "power pins");
    wr(ACC_ADDR_KEY, ACC_KEY_VALUE);
    wr(ACC_ADDR_POWER, 8'h00);
    wr(ACC_ADDR_OUTPROT, 8'hff);
    rd(ACC_ADDR_OUTPROT, ACC_MASK_OUTPROT);
    wr(ACC_ADDR_OUTPROT, 8'h00);
    for (int m = 0; m < 4; m++) begin
      d = 8'($urandom);
      wr(ACC_ADDR_INPROT, {d[7:2], 2'(m)});
      mode_q = 2'(m);
      wr(ACC_ADDR_FORMAT, d);
      xfer({20'h0, ACC_OP_READ, ACC_ADDR_FORMAT, 8'h00}, 20, fmt_word(d),
           40'hfffff);
      xfer(40'h0, 20, {32'h0, d & ACC_MASK_FORMAT}, 40'hfffff);
      rd(ACC_ADDR_INPROT, 8'(m));
    end
    r = 20'($urandom);
    xfer({20'h0, ACC_OP_READ, ACC_ADDR_INPROT, 8'h00}, 20, 40'h0,
         40'h0);
    xfer({r, ACC_OP_WRITE, ACC_ADDR_FORMAT, 8'h00}, 40,
         {12'h0, 8'h03, r}, '1);
    rd(ACC_ADDR_FORMAT, 8'h00);
    @(posedge clk_i);
    #1 sample_q = 16'($urandom);
    u_host.convert(1'b1);
    for (int k = 0; k < 50 && taken !== 1'b1; k++) @(negedge clk_i);
    if (taken !== 1'b1) begin
      num_errors++;
    end else begin
      @(posedge clk_i);
      #1 u_host.convert(1'b0);
      xfer(40'h0, 20, {20'h0, sample_q, 4'h0}, 40'hfffff);
    end
    // Let the watcher take the last note before the verdict
    for (int k = 0; k < 8 && exp_q.size() != 0; k++) @(posedge clk_i);
    if (exp_q.size() != 0) num_errors++;
    results();
  end
endmodule // acc_serial_port_tb

bind acc_serial_port acc_serial_port_properties u_prop (.*);
